//--- tb/pas_operator.sv
// Purpose: front-panel operator model pressing the four push-buttons
// Assumes: buttons are active-high pins behind a two-flop synchroniser
// Notes: each press outlasts the synchroniser and is released before the next
`timescale 1ns/1ps
`default_nettype none
module pas_operator (
	// clock
	input wire logic sys_clk_i,
	// buttons
	output var logic [3:0] button_o
);
	initial button_o = 4'h0;
	// hold goes down first so the key press is the newly pressed half of a combo
	task automatic press(input logic [3:0] hold, input logic [3:0] key);
		repeat (2) @(posedge sys_clk_i) button_o <= hold;
		repeat (6) @(posedge sys_clk_i) button_o <= hold | key;
		// pins idle low, so a released button reads 0, never the last level
		repeat (8) @(posedge sys_clk_i) button_o <= 4'h0;
	endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench for the process alarm sequencer
// Assumes: tick shortened to TICK cycles; one wait cycle per bus access
// Notes: outputs are sampled several edges after each stimulus
`timescale 1ns/1ps
`default_nettype none
module tb_top import pas_pkg::*; ();
	localparam int unsigned TICK = 20;
	localparam logic [3:0] K_PROG = 4'h1;
	localparam logic [3:0] K_UP = 4'h2;
	localparam logic [3:0] K_DN = 4'h4;
	localparam logic [3:0] K_EX = 4'h8;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic [7:0] adr = 8'h00;
	logic rd = 1'h0;
	logic wr_en = 1'h0;
	logic [31:0] wdat = 32'h0;
	logic signed [15:0] val = 16'sh0;
	logic [31:0] rdat;
	logic wreq;
	logic [3:0] btn;
	logic [1:0] sw;
	logic [1:0] ann;
	logic [4:0] mst;
	logic [15:0] mval;
	logic [31:0] q;
	logic [1:0] dsel;
	logic [31:0] bar;
	logic bflash;
	int n;
	int fails = 0;
	int tests_run = 0;
	always #12.5 sys_clk = ~sys_clk;
	pas_top #(.TICK_CYCLES(TICK)) u_pas_top (.sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr_en), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
		.avs_waitrequest_o(wreq), .display_value_i(val), .button_i(btn), .alarm_switch_o(sw),
		.annunciator_o(ann), .display_sel_o(dsel), .menu_state_o(mst), .menu_digit_o(),
		.menu_value_o(mval), .bar_seg_o(bar), .bar_scale_flash_o(bflash));
	pas_operator u_pas_operator (.sys_clk_i(sys_clk), .button_o(btn));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		adr <= a;
		wdat <= d;
		wr_en <= w;
		rd <= ~w;
		// waitrequest is judged at the rising edge, the same edge that takes the request
		do @(posedge sys_clk); while (wreq !== 1'h0);
		q = rdat;
		wr_en <= 1'h0;
		rd <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic step(input logic signed [15:0] v, input int n, input logic e);
		@(posedge sys_clk);
		val <= v;
		repeat (n) @(posedge sys_clk);
		chk({31'h0, sw[0]}, {31'h0, e});
	endtask
	task automatic mchk(input logic [4:0] e);
		chk({27'h0, mst}, {27'h0, e});
	endtask
	task automatic end_sim();
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		fails++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'h0;
		rdc(PAS_REG_CTRL, PAS_CTRL_RST);
		rdc(PAS_REG_CODE, {16'h0, PAS_CODE_RST});
		rdc(8'h40, 32'h0);
		bus(1'h1, PAS_REG_DLY1, 32'hfff);
		rdc(PAS_REG_DLY1, 32'he10);
		bus(1'h1, PAS_REG_SP1, 32'h64);
		bus(1'h1, PAS_REG_HYST1, 32'ha);
		bus(1'h1, PAS_REG_DLY1, 32'h0);
		bus(1'h1, PAS_REG_CTRL, 32'h3);
		step(16'sh64, 6, 1'h1);
		step(16'sh5a, 6, 1'h1);
		step(16'sh59, 6, 1'h0);
		step(16'shc8, 6, 1'h1);
		bus(1'h1, PAS_REG_CTRL, 32'h1);
		step(16'sh64, 6, 1'h1);
		step(16'sh6e, 6, 1'h1);
		step(16'sh6f, 6, 1'h0);
		bus(1'h1, PAS_REG_CTRL, 32'h0);
		step(16'sh32, 6, 1'h0);
		bus(1'h1, PAS_REG_CTRL, 32'h5);
		step(16'shc8, 6, 1'h1);
		step(16'sh32, 6, 1'h0);
		// three ticks of delay: 30 cycles is short of two ticks, so still waiting
		bus(1'h1, PAS_REG_DLY1, 32'h3);
		bus(1'h1, PAS_REG_CTRL, 32'h3);
		step(16'sh64, 30, 1'h0);
		step(16'sh0, 6, 1'h0);
		step(16'sh64, 30, 1'h0);
		step(16'sh64, 60, 1'h1);
		chk({31'h0, ann[0]}, 32'h1);
		step(16'sh64, 25, 1'h1);
		chk({31'h0, ann[0]}, 32'h1);
		bus(1'h1, PAS_REG_SIL1, 32'h3);
		u_pas_operator.press(4'h0, K_PROG);
		chk({31'h0, sw[0]}, 32'h0);
		bus(1'h0, PAS_REG_STAT, 32'h0);
		chk({28'h0, q[3:0]}, 32'h8);
		step(16'sh64, 100, 1'h1);
		// one active channel: tag shown on every other tick, so half of any two-tick window
		bus(1'h1, PAS_REG_CTRL, 32'h103);
		@(posedge sys_clk);
		n = 0;
		repeat (2 * TICK) begin
			@(posedge sys_clk);
			n += int'(dsel == PAS_SHOW_TAG1);
		end
		chk(n, 32'h14);
		u_pas_operator.press(K_UP, K_PROG);
		mchk(5'h01);
		bus(1'h1, PAS_REG_CTRL, 32'h203);
		u_pas_operator.press(K_UP, K_PROG);
		mchk(5'h08);
		u_pas_operator.press(4'h0, K_PROG);
		chk({16'h0, mval}, 32'h64);
		u_pas_operator.press(4'h0, K_UP);
		chk({16'h0, mval}, 32'h44c);
		u_pas_operator.press(4'h0, K_EX);
		mchk(5'h08);
		u_pas_operator.press(4'h0, K_DN);
		u_pas_operator.press(4'h0, K_PROG);
		chk({16'h0, mval}, 32'h0);
		u_pas_operator.press(4'h0, K_EX);
		u_pas_operator.press(4'h0, K_EX);
		mchk(5'h01);
		rdc(PAS_REG_SP1, 32'h44c);
		bus(1'h1, PAS_REG_CODE, 32'h1234);
		u_pas_operator.press(K_UP, K_PROG);
		mchk(5'h02);
		u_pas_operator.press(4'h0, K_PROG);
		mchk(5'h04);
		u_pas_operator.press(4'h0, K_EX);
		mchk(5'h01);
		u_pas_operator.press(K_UP, K_PROG);
		u_pas_operator.press(4'h0, K_PROG);
		// digit d gets d presses of up, top digit first
		for (int d = 1; d < 5; d++) begin
			repeat (d) u_pas_operator.press(4'h0, K_UP);
			if (d < 4) u_pas_operator.press(4'h0, K_PROG);
		end
		chk({16'h0, mval}, 32'h1234);
		u_pas_operator.press(4'h0, K_EX);
		mchk(5'h08);
		u_pas_operator.press(4'h0, K_EX);
		u_pas_operator.press(K_UP, K_PROG);
		repeat (15 * TICK) @(posedge sys_clk);
		mchk(5'h02);
		repeat (10 * TICK) @(posedge sys_clk);
		mchk(5'h01);
		// both channels read as low alarms: bar format invalid, scale blinks with no bars
		bus(1'h1, PAS_REG_CTRL, 32'h400);
		step(16'sha00, 6, 1'h0);
		chk(bar, 32'h0);
		n = 0;
		repeat (2 * TICK) begin
			@(posedge sys_clk);
			n += int'(bflash);
		end
		chk(n, 32'h14);
		// low setpoint in segment 2, high in segment 8, value in segment 5
		bus(1'h1, PAS_REG_SP2, 32'h1000);
		bus(1'h1, PAS_REG_CTRL, 32'h420);
		step(16'sha00, 6, 1'h0);
		chk(bar, 32'hffff_fe23);
		end_sim();
	end
endmodule
`default_nettype wire

//--- verilog/pas_pkg.sv
// Purpose: constants, types and register map of the process alarm sequencer
// Assumes: 40 MHz system clock, one-second tick derived from it
// Notes: registers are 32-bit words on byte addresses, narrower data in the low bits
// How it works
// - high alarm sets at setpoint, clears below setpoint minus hysteresis.
// - delay per channel 0..3600 seconds, zero activates at once.
// - output activates after uninterrupted delay; any break restarts the wait.
// - annunciator flashes while delay runs, steady once output active.
// - display alternation only while output active, not during delay or silence.
// - silence 0..3600 seconds; nonzero makes program button accept alarms.
// - accept drops output for silence time, then reactivates if condition holds.
// - annunciator flashes during silence until expiry or condition clears.
// - display alternates value and active tags, both tags in turn.
// - program plus up opens setpoint menu only when menu enabled.
// - four-digit code; all zeros means setpoint prompt directly.
// - after reset, setpoint menu disabled and code all zeros.
// - with code set, prompt, digit entry, exit shows setpoint prompt if match.
// - wrong code or twenty idle seconds returns to display mode.
// - up/down toggle setpoint prompts; exit returns to prompt, again to display.
// - one digit edited at a time; up/down change, program advances, exit stores.
// - bar format lights below low, above high setpoint, value as single bar.
// - value bar flashes when adjacent to either setpoint region.
// - value reaching a setpoint flashes that alarm's whole region.
// - bar format needs low first, high second, first below second, else scale flash.
// - per-channel enable turns alarm off without touching other parameters.
// - each channel selects high or low comparison direction.
// - output sense sets non-alarm switch state; alarm takes the opposite.
// - condition begins when value equals setpoint from the selected side.
package pas_pkg;
	localparam int unsigned PAS_CLK_HZ = 40_000_000;
	localparam int unsigned PAS_TICK_S = 1;
	localparam int unsigned PAS_TICK_CYC = PAS_TICK_S * PAS_CLK_HZ;
	localparam logic [11:0] PAS_MAX_SEC = 12'he10;
	localparam logic [11:0] PAS_MENU_TIMEOUT_S = 12'h014;
	localparam int unsigned PAS_BAR_SHIFT = 9;
	localparam int unsigned PAS_BAR_SEGS = 32;
	// register byte offsets
	localparam logic [7:0] PAS_REG_CTRL = 8'h00;
	localparam logic [7:0] PAS_REG_SP1 = 8'h04;
	localparam logic [7:0] PAS_REG_SP2 = 8'h08;
	localparam logic [7:0] PAS_REG_HYST1 = 8'h0c;
	localparam logic [7:0] PAS_REG_HYST2 = 8'h10;
	localparam logic [7:0] PAS_REG_DLY1 = 8'h14;
	localparam logic [7:0] PAS_REG_DLY2 = 8'h18;
	localparam logic [7:0] PAS_REG_SIL1 = 8'h1c;
	localparam logic [7:0] PAS_REG_SIL2 = 8'h20;
	localparam logic [7:0] PAS_REG_CODE = 8'h24;
	localparam logic [7:0] PAS_REG_BARZ = 8'h28;
	localparam logic [7:0] PAS_REG_STAT = 8'h2c;
	// control register fields; channel c uses bits 4*c .. 4*c+2
	localparam int unsigned PAS_CH_STRIDE = 4;
	localparam int unsigned PAS_B_EN = 0;
	localparam int unsigned PAS_B_HIGH = 1;
	localparam int unsigned PAS_B_NC = 2;
	localparam int unsigned PAS_B_FLASH = 8;
	localparam int unsigned PAS_B_ACCESS = 9;
	localparam int unsigned PAS_B_BARFMT = 10;
	localparam logic [31:0] PAS_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] PAS_CODE_RST = 16'h0000;
	// button pins
	localparam int unsigned PAS_BTN_PROG = 0;
	localparam int unsigned PAS_BTN_UP = 1;
	localparam int unsigned PAS_BTN_DOWN = 2;
	localparam int unsigned PAS_BTN_EXIT = 3;
	localparam logic [1:0] PAS_SHOW_VALUE = 2'h0;
	localparam logic [1:0] PAS_SHOW_TAG1 = 2'h1;
	localparam logic [1:0] PAS_SHOW_TAG2 = 2'h2;
	localparam logic [1:0] PAS_DIGIT_TOP = 2'h3;

	typedef enum logic [3:0] {
		CH_IDLE = 4'h1,
		CH_DELAY = 4'h2,
		CH_ACTIVE = 4'h4,
		CH_SILENCE = 4'h8
	} pas_ch_state_t;

	typedef enum logic [4:0] {
		M_DISP = 5'h01,
		M_CODE = 5'h02,
		M_CODE_ED = 5'h04,
		M_SPSEL = 5'h08,
		M_SP_ED = 5'h10
	} pas_menu_t;

	typedef struct packed {
		logic en;
		logic high;
		logic nc;
		logic signed [15:0] sp;
		logic [15:0] hyst;
		logic [11:0] dly;
		logic [11:0] silence_time;
	} pas_chan_cfg_t;
endpackage

//--- verilog/pas_top.sv
// Purpose: two-channel process alarm sequencer with setpoint menu and bargraph
// Assumes: display value comes from logic on sys_clk_i; buttons are raw pins, active high
// Notes: registers answer with exactly one wait cycle
`timescale 1ns/1ps
`default_nettype none
module pas_top import pas_pkg::*; #(
	parameter int unsigned TICK_CYCLES = PAS_TICK_CYC
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	// avalon-mm slave
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output var logic [31:0] avs_readdata_o,
	output var logic avs_waitrequest_o,
	// process value and front panel
	input wire logic signed [15:0] display_value_i,
	input wire logic [3:0] button_i,
	// alarm outputs and indications
	output var logic [1:0] alarm_switch_o,
	output var logic [1:0] annunciator_o,
	output var logic [1:0] display_sel_o,
	output var logic [4:0] menu_state_o,
	output var logic [1:0] menu_digit_o,
	output var logic [15:0] menu_value_o,
	output var logic [31:0] bar_seg_o,
	output var logic bar_scale_flash_o
);
	function automatic logic [11:0] clamp_sec(input logic [31:0] d);
		clamp_sec = (d[31:12] != 20'h0 || d[11:0] > PAS_MAX_SEC) ? PAS_MAX_SEC : d[11:0];
	endfunction

	function automatic logic [15:0] pow10(input logic [1:0] d);
		case (d)
			2'h0: pow10 = 16'h0001;
			2'h1: pow10 = 16'h000a;
			2'h2: pow10 = 16'h0064;
			default: pow10 = 16'h03e8;
		endcase
	endfunction

	function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] d, input logic up);
		logic [3:0] n;
		logic [15:0] r;
		r = v;
		n = v[4*d +: 4];
		if (up) begin
			n = (n >= 4'h9) ? 4'h0 : n + 4'h1;
		end else begin
			n = (n == 4'h0 || n > 4'h9) ? 4'h9 : n - 4'h1;
		end
		r[4*d +: 4] = n;
		bcd_step = r;
	endfunction

	function automatic logic [4:0] seg_of(input logic signed [15:0] v, input logic signed [15:0] z);
		logic signed [16:0] diff;
		logic [16:0] sh;
		diff = 17'(v) - 17'(z);
		sh = 17'(diff >>> PAS_BAR_SHIFT);
		if (diff < 0) begin
			seg_of = 5'h00;
		end else if (sh > 17'(PAS_BAR_SEGS - 1)) begin
			seg_of = 5'h1f;
		end else begin
			seg_of = sh[4:0];
		end
	endfunction

	// shared state
	logic [31:0] ctrl_r;
	logic [15:0] code_r;
	logic signed [15:0] bar_zero_r;
	pas_chan_cfg_t cfg [2];
	logic [1:0] ch_en, ch_high, ch_nc;
	logic signed [15:0] ch_sp [2];
	logic [15:0] ch_hyst [2];
	logic [11:0] ch_dly [2];
	logic [11:0] ch_sil [2];
	pas_ch_state_t st_r [2];
	logic [11:0] sec_r [2];
	logic [1:0] cond_r;
	pas_menu_t menu_r;
	logic sel_r;
	logic [15:0] entry_r;
	logic signed [15:0] edit_r;
	logic [11:0] idle_r;
	logic [25:0] tick_cnt_r;
	logic tick_r, blink_r;
	logic [1:0] step_r;
	logic [3:0] btn_s1_r, btn_s2_r, btn_prev_r;
	logic [3:0] press;
	logic bus_wr, any_press, combo, accept, sp_store, bar_valid;
	logic [31:0] rd_mux;

	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ch_en[c] = ctrl_r[PAS_CH_STRIDE*c + PAS_B_EN];
			ch_high[c] = ctrl_r[PAS_CH_STRIDE*c + PAS_B_HIGH];
			ch_nc[c] = ctrl_r[PAS_CH_STRIDE*c + PAS_B_NC];
			cfg[c] = '{en: ch_en[c], high: ch_high[c], nc: ch_nc[c], sp: ch_sp[c], hyst: ch_hyst[c],
				dly: ch_dly[c], silence_time: ch_sil[c]};
		end
	end

	// avalon slave: one wait cycle, then the taking edge
	assign bus_wr = avs_write_i & ~avs_waitrequest_o;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			PAS_REG_CTRL: rd_mux = ctrl_r;
			PAS_REG_SP1: rd_mux = 32'(unsigned'(cfg[0].sp));
			PAS_REG_SP2: rd_mux = 32'(unsigned'(cfg[1].sp));
			PAS_REG_HYST1: rd_mux = 32'(cfg[0].hyst);
			PAS_REG_HYST2: rd_mux = 32'(cfg[1].hyst);
			PAS_REG_DLY1: rd_mux = 32'(cfg[0].dly);
			PAS_REG_DLY2: rd_mux = 32'(cfg[1].dly);
			PAS_REG_SIL1: rd_mux = 32'(cfg[0].silence_time);
			PAS_REG_SIL2: rd_mux = 32'(cfg[1].silence_time);
			PAS_REG_CODE: rd_mux = 32'(code_r);
			PAS_REG_BARZ: rd_mux = 32'(unsigned'(bar_zero_r));
			PAS_REG_STAT: rd_mux = {17'h0, menu_r, cond_r, st_r[1], st_r[0]};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avs_readdata_o <= 32'h0000_0000;
		end else if (avs_read_i & avs_waitrequest_o) begin
			avs_readdata_o <= rd_mux;
		end
	end

	// configuration; a bus write wins over a menu store in the same cycle
	assign sp_store = (menu_r == M_SP_ED) & press[PAS_BTN_EXIT];
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl_r <= PAS_CTRL_RST;
			code_r <= PAS_CODE_RST;
			bar_zero_r <= 16'sh0000;
			for (int c = 0; c < 2; c++) begin
				ch_sp[c] <= 16'sh0000;
				ch_hyst[c] <= 16'h0000;
				ch_dly[c] <= 12'h000;
				ch_sil[c] <= 12'h000;
			end
		end else if (bus_wr) begin
			case (avs_address_i)
				PAS_REG_CTRL: ctrl_r <= avs_writedata_i;
				PAS_REG_SP1: ch_sp[0] <= avs_writedata_i[15:0];
				PAS_REG_SP2: ch_sp[1] <= avs_writedata_i[15:0];
				PAS_REG_HYST1: ch_hyst[0] <= avs_writedata_i[15:0];
				PAS_REG_HYST2: ch_hyst[1] <= avs_writedata_i[15:0];
				PAS_REG_DLY1: ch_dly[0] <= clamp_sec(avs_writedata_i);
				PAS_REG_DLY2: ch_dly[1] <= clamp_sec(avs_writedata_i);
				PAS_REG_SIL1: ch_sil[0] <= clamp_sec(avs_writedata_i);
				PAS_REG_SIL2: ch_sil[1] <= clamp_sec(avs_writedata_i);
				PAS_REG_CODE: code_r <= avs_writedata_i[15:0];
				PAS_REG_BARZ: bar_zero_r <= avs_writedata_i[15:0];
				default: ;
			endcase
		end else if (sp_store) begin
			ch_sp[sel_r] <= edit_r;
		end
	end

	// one-second tick shared by all timers
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt_r <= 26'h0;
			tick_r <= 1'b0;
			blink_r <= 1'b0;
		end else begin
			tick_r <= (tick_cnt_r == 26'(TICK_CYCLES - 1));
			tick_cnt_r <= (tick_cnt_r == 26'(TICK_CYCLES - 1)) ? 26'h0 : tick_cnt_r + 26'h1;
			if (tick_r) begin
				blink_r <= ~blink_r;
			end
		end
	end

	// buttons are asynchronous pins
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			btn_s1_r <= 4'h0;
			btn_s2_r <= 4'h0;
			btn_prev_r <= 4'h0;
		end else begin
			btn_s1_r <= button_i;
			btn_s2_r <= btn_s1_r;
			btn_prev_r <= btn_s2_r;
		end
	end
	assign press = btn_s2_r & ~btn_prev_r;
	assign any_press = |press;
	assign combo = btn_s2_r[PAS_BTN_PROG] & btn_s2_r[PAS_BTN_UP] & (press[PAS_BTN_PROG] | press[PAS_BTN_UP]);
	// a program press with up held is a menu request, never an accept
	assign accept = (menu_r == M_DISP) & press[PAS_BTN_PROG] & ~btn_s2_r[PAS_BTN_UP];

	// condition with hysteresis
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cond_r <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				if (!cfg[c].en) begin
					cond_r[c] <= 1'b0;
				end else if (cfg[c].high) begin
					if (display_value_i >= cfg[c].sp) begin
						cond_r[c] <= 1'b1;
					end else if (17'(display_value_i) < 17'(cfg[c].sp) - 17'(signed'({1'b0, cfg[c].hyst}))) begin
						cond_r[c] <= 1'b0;
					end
				end else begin
					if (display_value_i <= cfg[c].sp) begin
						cond_r[c] <= 1'b1;
					end else if (17'(display_value_i) > 17'(cfg[c].sp) + 17'(signed'({1'b0, cfg[c].hyst}))) begin
						cond_r[c] <= 1'b0;
					end
				end
			end
		end
	end

	// per-channel delay and silence sequencing
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int c = 0; c < 2; c++) begin
				st_r[c] <= CH_IDLE;
				sec_r[c] <= 12'h000;
			end
		end else begin
			for (int c = 0; c < 2; c++) begin
				case (st_r[c])
					CH_IDLE: begin
						sec_r[c] <= 12'h000;
						if (cond_r[c]) begin
							st_r[c] <= (cfg[c].dly == 12'h000) ? CH_ACTIVE : CH_DELAY;
						end
					end
					CH_DELAY: begin
						if (!cond_r[c]) begin
							st_r[c] <= CH_IDLE;
						end else if (tick_r) begin
							sec_r[c] <= sec_r[c] + 12'h001;
							if (sec_r[c] + 12'h001 >= cfg[c].dly) begin
								st_r[c] <= CH_ACTIVE;
							end
						end
					end
					CH_ACTIVE: begin
						sec_r[c] <= 12'h000;
						if (!cond_r[c]) begin
							st_r[c] <= CH_IDLE;
						end else if (accept && cfg[c].silence_time != 12'h000) begin
							st_r[c] <= CH_SILENCE;
						end
					end
					CH_SILENCE: begin
						if (!cond_r[c]) begin
							st_r[c] <= CH_IDLE;
						end else if (tick_r) begin
							sec_r[c] <= sec_r[c] + 12'h001;
							if (sec_r[c] + 12'h001 >= cfg[c].silence_time) begin
								st_r[c] <= CH_ACTIVE;
							end
						end
					end
					default: st_r[c] <= CH_IDLE;
				endcase
			end
		end
	end

	// switch, annunciator and display alternation
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			alarm_switch_o <= 2'b00;
			annunciator_o <= 2'b00;
			display_sel_o <= PAS_SHOW_VALUE;
			step_r <= 2'h0;
		end else begin
			for (int c = 0; c < 2; c++) begin
				alarm_switch_o[c] <= (st_r[c] == CH_ACTIVE) ? ~cfg[c].nc : cfg[c].nc;
				case (st_r[c])
					CH_ACTIVE: annunciator_o[c] <= 1'b1;
					CH_DELAY: annunciator_o[c] <= blink_r;
					CH_SILENCE: annunciator_o[c] <= blink_r;
					default: annunciator_o[c] <= 1'b0;
				endcase
			end
			if (tick_r) begin
				step_r <= step_r + 2'h1;
			end
			if (!ctrl_r[PAS_B_FLASH] || (st_r[0] != CH_ACTIVE && st_r[1] != CH_ACTIVE) || !step_r[0]) begin
				display_sel_o <= PAS_SHOW_VALUE;
			end else if (st_r[0] == CH_ACTIVE && st_r[1] == CH_ACTIVE) begin
				display_sel_o <= step_r[1] ? PAS_SHOW_TAG2 : PAS_SHOW_TAG1;
			end else begin
				display_sel_o <= (st_r[0] == CH_ACTIVE) ? PAS_SHOW_TAG1 : PAS_SHOW_TAG2;
			end
		end
	end

	// setpoint access menu
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			menu_r <= M_DISP;
			sel_r <= 1'b0;
			entry_r <= 16'h0000;
			edit_r <= 16'sh0000;
			menu_digit_o <= PAS_DIGIT_TOP;
			idle_r <= 12'h000;
		end else begin
			if (menu_r == M_DISP || any_press) begin
				idle_r <= 12'h000;
			end else if (tick_r) begin
				idle_r <= idle_r + 12'h001;
			end
			case (menu_r)
				M_DISP: begin
					if (combo && ctrl_r[PAS_B_ACCESS]) begin
						sel_r <= 1'b0;
						menu_r <= (code_r == PAS_CODE_RST) ? M_SPSEL : M_CODE;
					end
				end
				M_CODE: begin
					if (press[PAS_BTN_PROG]) begin
						entry_r <= 16'h0000;
						menu_digit_o <= PAS_DIGIT_TOP;
						menu_r <= M_CODE_ED;
					end else if (press[PAS_BTN_EXIT]) begin
						menu_r <= M_DISP;
					end
				end
				M_CODE_ED: begin
					if (press[PAS_BTN_UP] || press[PAS_BTN_DOWN]) begin
						entry_r <= bcd_step(entry_r, menu_digit_o, press[PAS_BTN_UP]);
					end else if (press[PAS_BTN_PROG]) begin
						menu_digit_o <= menu_digit_o - 2'h1;
					end else if (press[PAS_BTN_EXIT]) begin
						menu_r <= (entry_r == code_r) ? M_SPSEL : M_DISP;
					end
				end
				M_SPSEL: begin
					if (press[PAS_BTN_UP] || press[PAS_BTN_DOWN]) begin
						sel_r <= ~sel_r;
					end else if (press[PAS_BTN_PROG]) begin
						edit_r <= cfg[sel_r].sp;
						menu_digit_o <= PAS_DIGIT_TOP;
						menu_r <= M_SP_ED;
					end else if (press[PAS_BTN_EXIT]) begin
						menu_r <= M_DISP;
					end
				end
				M_SP_ED: begin
					if (press[PAS_BTN_UP]) begin
						edit_r <= edit_r + signed'(pow10(menu_digit_o));
					end else if (press[PAS_BTN_DOWN]) begin
						edit_r <= edit_r - signed'(pow10(menu_digit_o));
					end else if (press[PAS_BTN_PROG]) begin
						menu_digit_o <= menu_digit_o - 2'h1;
					end else if (press[PAS_BTN_EXIT]) begin
						menu_r <= M_SPSEL;
					end
				end
				default: menu_r <= M_DISP;
			endcase
			if (menu_r != M_DISP && !any_press && idle_r >= PAS_MENU_TIMEOUT_S) begin
				menu_r <= M_DISP;
			end
		end
	end
	assign menu_state_o = menu_r;

	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			menu_value_o <= 16'h0000;
		end else begin
			menu_value_o <= (menu_r == M_SP_ED) ? edit_r : entry_r;
		end
	end

	// bargraph
	assign bar_valid = !cfg[0].high && cfg[1].high && (cfg[0].sp < cfg[1].sp);
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			bar_seg_o <= 32'h0000_0000;
			bar_scale_flash_o <= 1'b0;
		end else begin
			for (int i = 0; i < PAS_BAR_SEGS; i++) begin
				if (!ctrl_r[PAS_B_BARFMT]) begin
					bar_seg_o[i] <= (5'(i) <= seg_of(display_value_i, bar_zero_r));
				end else if (!bar_valid) begin
					bar_seg_o[i] <= 1'b0;
				end else if (5'(i) < seg_of(cfg[0].sp, bar_zero_r)) begin
					bar_seg_o[i] <= ~cond_r[0] | blink_r;
				end else if (5'(i) > seg_of(cfg[1].sp, bar_zero_r)) begin
					bar_seg_o[i] <= ~cond_r[1] | blink_r;
				end else if (5'(i) == seg_of(display_value_i, bar_zero_r)) begin
					if (5'(i) == seg_of(cfg[0].sp, bar_zero_r) || 5'(i) == seg_of(cfg[1].sp, bar_zero_r)) begin
						bar_seg_o[i] <= blink_r;
					end else begin
						bar_seg_o[i] <= 1'b1;
					end
				end else begin
					bar_seg_o[i] <= 1'b0;
				end
			end
			bar_scale_flash_o <= ctrl_r[PAS_B_BARFMT] & ~bar_valid & blink_r;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_accept_active;
		accept && st_r[0] == CH_ACTIVE && cond_r[0] && cfg[0].silence_time != 12'h000;
	endsequence
	sequence s_silenced;
		st_r[0] == CH_SILENCE ##1 alarm_switch_o[0] == cfg[0].nc;
	endsequence

	a_hyst_high_hold: assert property (cfg[0].en && cfg[0].high && cond_r[0] &&
		17'(display_value_i) >= 17'(cfg[0].sp) - 17'(signed'({1'b0, cfg[0].hyst})) |=> cond_r[0])
		else $error("high alarm cleared inside hysteresis band");
	a_delay_zero_direct: assert property (st_r[0] == CH_IDLE && cond_r[0] && cfg[0].dly == 12'h000
		|=> st_r[0] == CH_ACTIVE) else $error("zero delay did not activate at once");
	a_delay_break: assert property (st_r[0] == CH_DELAY && !cond_r[0] |=> st_r[0] == CH_IDLE)
		else $error("broken condition did not restart delay");
	a_annun_steady: assert property (st_r[0] == CH_ACTIVE ##1 st_r[0] == CH_ACTIVE |-> annunciator_o[0])
		else $error("annunciator not steady while output active");
	a_flash_gated: assert property (display_sel_o != PAS_SHOW_VALUE |->
		$past(st_r[0]) == CH_ACTIVE || $past(st_r[1]) == CH_ACTIVE) else $error("display alternated without active output");
	a_accept_silence: assert property (s_accept_active |=> s_silenced)
		else $error("accept did not silence the output");
	a_access_off: assert property (menu_r == M_DISP && !ctrl_r[PAS_B_ACCESS] |=> menu_r == M_DISP)
		else $error("menu opened while access disabled");
	a_code_zero: assert property (menu_r == M_DISP && combo && ctrl_r[PAS_B_ACCESS] && code_r == 16'h0000
		|=> menu_r == M_SPSEL) else $error("unprotected menu did not show setpoint prompt");
	a_wrong_code: assert property (menu_r == M_CODE_ED && press[PAS_BTN_EXIT] && entry_r != code_r
		&& !press[PAS_BTN_UP] && !press[PAS_BTN_DOWN] && !press[PAS_BTN_PROG]
		|=> menu_r == M_DISP) else $error("wrong code did not return to display");
	a_bar_invalid: assert property (ctrl_r[PAS_B_BARFMT] && !bar_valid ##1 ctrl_r[PAS_B_BARFMT]
		|-> bar_seg_o == 32'h0000_0000) else $error("bars lit under invalid bar configuration");
endmodule
`default_nettype wire
